// ===== rtl/abu_break_unit.sv
// Address breakpoint unit: compares program addresses, raises break requests,
// holds timers during a break, disables the watchdog there only with test voltage, and records low-power exits.
// Assumes the CPU end of abu_if on the same clock and software access via the link.
//
// Function
// - Request break when bus address equals match registers
// - Only program-counter addresses may trigger a match
// - CPU substitutes soft interrupt after current instruction
// - Vector normal or monitor location by mode
// - Writing one to active flag starts break
// - Match on last cycle breaks at once
// - Return from interrupt ends the break state
// - Timers hold while break is active
// - Watchdog off in break with test voltage
// - Flag clearing in break needs clear enable
// - Comparator keeps working during wait mode
// - Break in stop wakes and flags exit
// - Software may rewind return address for re-entry
// - Writing zero clears the wait exit flag
// - Full match needs enable; reset clears it
// - Match sets active flag; software/reset clear
// - Reset clears both match address bytes
// - Break leaving wait also sets exit flag
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module abu_break_unit #(
	parameter int ADDR_W = abu_pkg::ADDR_W
) (
	// Clock, reset, enable
	input  wire logic   CLK,
	input  wire logic   RST,
	input  wire logic   CE,
	// Link to the CPU core
	abu_if.dev          LINK,
	// Pins
	input  wire logic   MONITOR_MODE,
	input  wire logic   TEST_VOLT_PIN,
	// Controls to neighbouring blocks
	output logic        TIMER_HOLD,
	output logic        WDOG_DISABLE,
	output logic        FLAG_CLEAR_OK,
	// Interrupt
	output logic        IRQ
);
	import abu_pkg::*;

	if (ADDR_W != abu_pkg::ADDR_W) begin : g_chk
		$error("abu_break_unit: ADDR_W must match the link address width");
	end

	logic      test_volt;
	logic      monitor;
	logic      en_ff;
	logic      active_ff;
	abu_byte_t hi_ff;
	abu_byte_t lo_ff;
	logic      wexit_ff;
	logic      fce_ff;
	abu_irq_t  istat_ff;
	abu_irq_t  imask_ff;
	logic      req_ff;
	abu_byte_t rdata_ff;
	abu_addr_t vec_ff;
	logic      hold_ff;
	logic      wdog_ff;
	logic      fclr_ff;
	logic      irq_ff;
	logic      match_now;
	logic      sw_start;
	logic      start;
	logic      wake;
	logic      wr_ctrl;
	logic      wr_wstat;
	logic      wr_istat;
	abu_irq_t  ev;

	// Pins come from outside the clock domain
	abu_sync2 u_sync_tv (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.d   (TEST_VOLT_PIN),
		.q   (test_volt)
	);

	abu_sync2 u_sync_mon (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.d   (MONITOR_MODE),
		.q   (monitor)
	);

	// Full-width compare, program fetches only, independent of wait
	assign match_now = en_ff && LINK.addr_from_pc && !LINK.in_break
		&& (LINK.bus_addr == {hi_ff, lo_ff});

	assign wr_ctrl  = LINK.reg_wr && (LINK.reg_addr == OFS_CTRL);
	assign wr_wstat = LINK.reg_wr && (LINK.reg_addr == OFS_WAIT_STAT);
	assign wr_istat = LINK.reg_wr && (LINK.reg_addr == OFS_IRQ_STAT);

	assign sw_start = wr_ctrl && LINK.reg_wdata[BIT_ACTIVE];
	assign start    = match_now || sw_start;

	// Request seen by a waiting or stopped core wakes it
	assign wake = req_ff && (LINK.low_wait || LINK.low_stop);
	assign ev   = {wake, start};

	// Enable bit
	always_ff @(posedge CLK) begin
		if (RST) begin
			en_ff <= 1'b0;
		end else if (CE) begin
			if (wr_ctrl) begin
				en_ff <= LINK.reg_wdata[BIT_MATCH_EN];
			end
		end
	end

	// Active flag, set wins over a clearing write
	always_ff @(posedge CLK) begin
		if (RST) begin
			active_ff <= 1'b0;
		end else if (CE) begin
			if (start) begin
				active_ff <= 1'b1;
			end else if (wr_ctrl) begin
				active_ff <= LINK.reg_wdata[BIT_ACTIVE];
			end
		end
	end

	// Match address bytes
	always_ff @(posedge CLK) begin
		if (RST) begin
			hi_ff <= RST_BYTE;
			lo_ff <= RST_BYTE;
		end else if (CE) begin
			if (LINK.reg_wr && (LINK.reg_addr == OFS_MATCH_HI)) begin
				hi_ff <= LINK.reg_wdata;
			end
			if (LINK.reg_wr && (LINK.reg_addr == OFS_MATCH_LO)) begin
				lo_ff <= LINK.reg_wdata;
			end
		end
	end

	// Registered request, held until the core enters the break state
	always_ff @(posedge CLK) begin
		if (RST) begin
			req_ff <= 1'b0;
		end else if (CE) begin
			if (start) begin
				req_ff <= 1'b1;
			end else if (LINK.in_break) begin
				req_ff <= 1'b0;
			end
		end
	end

	// Wait exit flag, cleared by writing zero
	always_ff @(posedge CLK) begin
		if (RST) begin
			wexit_ff <= 1'b0;
		end else if (CE) begin
			if (wake) begin
				wexit_ff <= 1'b1;
			end else if (wr_wstat && !LINK.reg_wdata[BIT_WAIT_EXIT]) begin
				wexit_ff <= 1'b0;
			end
		end
	end

	// Flag clear enable
	always_ff @(posedge CLK) begin
		if (RST) begin
			fce_ff <= 1'b0;
		end else if (CE) begin
			if (LINK.reg_wr && (LINK.reg_addr == OFS_FLAG_CTRL)) begin
				fce_ff <= LINK.reg_wdata[BIT_FLAG_CLEAR];
			end
		end
	end

	// Interrupt status: events set, write one clears, guarded in break
	always_ff @(posedge CLK) begin
		if (RST) begin
			istat_ff <= RST_IRQ;
		end else if (CE) begin
			if (wr_istat && (!LINK.in_break || fce_ff)) begin
				istat_ff <= (istat_ff & ~LINK.reg_wdata[IRQ_W-1:0]) | ev;
			end else begin
				istat_ff <= istat_ff | ev;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			imask_ff <= RST_IRQ;
		end else if (CE) begin
			if (LINK.reg_wr && (LINK.reg_addr == OFS_IRQ_MASK)) begin
				imask_ff <= LINK.reg_wdata[IRQ_W-1:0];
			end
		end
	end

	// One cycle behind status; keeps the output glitch-free
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_ff <= 1'b0;
		end else if (CE) begin
			irq_ff <= |(istat_ff & imask_ff);
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge CLK) begin
		if (RST) begin
			rdata_ff <= RST_BYTE;
		end else if (CE) begin
			rdata_ff <= RST_BYTE;
			if (LINK.reg_rd) begin
				if (LINK.reg_addr == OFS_CTRL) begin
					rdata_ff[BIT_MATCH_EN] <= en_ff;
					rdata_ff[BIT_ACTIVE]   <= active_ff;
				end else if (LINK.reg_addr == OFS_MATCH_HI) begin
					rdata_ff <= hi_ff;
				end else if (LINK.reg_addr == OFS_MATCH_LO) begin
					rdata_ff <= lo_ff;
				end else if (LINK.reg_addr == OFS_WAIT_STAT) begin
					rdata_ff[BIT_WAIT_EXIT] <= wexit_ff;
				end else if (LINK.reg_addr == OFS_FLAG_CTRL) begin
					rdata_ff[BIT_FLAG_CLEAR] <= fce_ff;
				end else if (LINK.reg_addr == OFS_IRQ_STAT) begin
					rdata_ff[IRQ_W-1:0] <= istat_ff;
				end else if (LINK.reg_addr == OFS_IRQ_MASK) begin
					rdata_ff[IRQ_W-1:0] <= imask_ff;
				end
			end
		end
	end

	// Break-state controls to the rest of the chip
	always_ff @(posedge CLK) begin
		if (RST) begin
			hold_ff <= 1'b0;
			wdog_ff <= 1'b0;
			fclr_ff <= 1'b1;
		end else if (CE) begin
			hold_ff <= LINK.in_break;
			wdog_ff <= LINK.in_break && test_volt;
			fclr_ff <= !LINK.in_break || fce_ff;
		end
	end

	// Vector location follows the synchronised monitor strap
	always_ff @(posedge CLK) begin
		if (RST) begin
			vec_ff <= VEC_NORMAL;
		end else if (CE) begin
			vec_ff <= monitor ? VEC_MONITOR : VEC_NORMAL;
		end
	end

	assign LINK.brk_req   = req_ff;
	assign LINK.reg_rdata = rdata_ff;
	assign LINK.vec_addr  = vec_ff;
	assign TIMER_HOLD     = hold_ff;
	assign WDOG_DISABLE   = wdog_ff;
	assign FLAG_CLEAR_OK  = fclr_ff;
	assign IRQ            = irq_ff;

endmodule : abu_break_unit

// ===== rtl/abu_cpu_end.sv
// CPU-core end of the breakpoint link: takes breaks at instruction boundaries,
// leaves wait or stop on a request, and ends the break on a return.
// Assumes core sequencing signals on the same clock; software access passes through.
`timescale 1ns/1ps
module abu_cpu_end (
	// Clock, reset, enable
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic                  CE,
	// Link to the breakpoint unit
	abu_if.cpu                         LINK,
	// Software register port
	input  wire abu_pkg::abu_reg_addr_t SW_ADDR,
	input  wire abu_pkg::abu_byte_t     SW_WDATA,
	input  wire logic                  SW_WR,
	input  wire logic                  SW_RD,
	output abu_pkg::abu_byte_t          SW_RDATA,
	// Core sequencing
	input  wire abu_pkg::abu_addr_t     CORE_ADDR,
	input  wire logic                  CORE_ADDR_FROM_PC,
	input  wire logic                  INSTR_LAST,
	input  wire logic                  RTI_EXEC,
	input  wire logic                  WAIT_EXEC,
	input  wire logic                  STOP_EXEC,
	// Core results
	output logic                       SUBST_SWI,
	output abu_pkg::abu_addr_t          VECTOR_ADDR,
	output logic                       BREAK_STATE,
	output logic                       WAIT_STATE,
	output logic                       STOP_STATE
);
	import abu_pkg::*;

	abu_cpu_state_t state_ff;
	logic           boundary_ff;
	logic           subst_ff;
	abu_addr_t      vec_ff;

	// Bus and software strobes are wires of the same clock
	assign LINK.bus_addr     = CORE_ADDR;
	assign LINK.addr_from_pc = CORE_ADDR_FROM_PC;
	assign LINK.reg_addr     = SW_ADDR;
	assign LINK.reg_wdata    = SW_WDATA;
	assign LINK.reg_wr       = SW_WR;
	assign LINK.reg_rd       = SW_RD;
	assign SW_RDATA          = LINK.reg_rdata;

	// Opcode slot opens the cycle after an instruction's last
	always_ff @(posedge CLK) begin
		if (RST) begin
			boundary_ff <= 1'b0;
		end else if (CE) begin
			boundary_ff <= INSTR_LAST;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_ff <= CPU_RUN;
			subst_ff <= 1'b0;
			vec_ff   <= RST_ADDR;
		end else if (CE) begin
			subst_ff <= 1'b0;
			case (state_ff)
				CPU_RUN: begin
					if (boundary_ff && LINK.brk_req) begin
						state_ff <= CPU_BREAK;
						subst_ff <= 1'b1;
						vec_ff   <= LINK.vec_addr;
					end else if (WAIT_EXEC) begin
						state_ff <= CPU_WAIT;
					end else if (STOP_EXEC) begin
						state_ff <= CPU_STOP;
					end
				end
				CPU_WAIT, CPU_STOP: begin
					if (LINK.brk_req) begin
						state_ff <= CPU_BREAK;
						subst_ff <= 1'b1;
						vec_ff   <= LINK.vec_addr;
					end
				end
				CPU_BREAK: begin
					if (RTI_EXEC && INSTR_LAST) begin
						state_ff <= CPU_RUN;
					end
				end
				default: begin
					state_ff <= CPU_RUN;
				end
			endcase
		end
	end

	assign LINK.in_break  = (state_ff == CPU_BREAK);
	assign LINK.low_wait  = (state_ff == CPU_WAIT);
	assign LINK.low_stop  = (state_ff == CPU_STOP);
	assign SUBST_SWI      = subst_ff;
	assign VECTOR_ADDR    = vec_ff;
	assign BREAK_STATE    = (state_ff == CPU_BREAK);
	assign WAIT_STATE     = (state_ff == CPU_WAIT);
	assign STOP_STATE     = (state_ff == CPU_STOP);

endmodule : abu_cpu_end

// ===== rtl/abu_if.sv
// Link between the breakpoint unit and the CPU core.
// Assumes both ends run on the same clock; the testbench joins them.
`timescale 1ns/1ps
interface abu_if;
	import abu_pkg::*;

	abu_addr_t     bus_addr;
	logic          addr_from_pc;
	abu_reg_addr_t reg_addr;
	abu_byte_t     reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	abu_byte_t     reg_rdata;
	logic          brk_req;
	abu_addr_t     vec_addr;
	logic          in_break;
	logic          low_wait;
	logic          low_stop;

	modport dev (
		input  bus_addr, addr_from_pc, reg_addr, reg_wdata, reg_wr, reg_rd,
		input  in_break, low_wait, low_stop,
		output reg_rdata, brk_req, vec_addr
	);

	modport cpu (
		output bus_addr, addr_from_pc, reg_addr, reg_wdata, reg_wr, reg_rd,
		output in_break, low_wait, low_stop,
		input  reg_rdata, brk_req, vec_addr
	);

endinterface : abu_if

// ===== rtl/abu_pkg.sv
// Shared constants and types for the address breakpoint unit and its CPU end.
// Assumes one 100 MHz clock and byte-wide register access.
package abu_pkg;

	// Widths
	localparam int ADDR_W   = 16;
	localparam int DATA_W   = 8;
	localparam int REG_AW   = 3;
	localparam int IRQ_W    = 2;

	typedef logic [ADDR_W-1:0] abu_addr_t;
	typedef logic [DATA_W-1:0] abu_byte_t;
	typedef logic [REG_AW-1:0] abu_reg_addr_t;
	typedef logic [IRQ_W-1:0]  abu_irq_t;

	// Register offsets
	localparam abu_reg_addr_t OFS_CTRL      = 3'h0;
	localparam abu_reg_addr_t OFS_MATCH_HI  = 3'h1;
	localparam abu_reg_addr_t OFS_MATCH_LO  = 3'h2;
	localparam abu_reg_addr_t OFS_WAIT_STAT = 3'h3;
	localparam abu_reg_addr_t OFS_FLAG_CTRL = 3'h4;
	localparam abu_reg_addr_t OFS_IRQ_STAT  = 3'h5;
	localparam abu_reg_addr_t OFS_IRQ_MASK  = 3'h6;

	// Field positions
	localparam int BIT_MATCH_EN   = 7;
	localparam int BIT_ACTIVE     = 6;
	localparam int BIT_WAIT_EXIT  = 1;
	localparam int BIT_FLAG_CLEAR = 7;
	localparam int IRQ_BIT_BREAK  = 0;
	localparam int IRQ_BIT_WAKE   = 1;

	// Reset values
	localparam abu_byte_t RST_BYTE = 8'h00;
	localparam abu_irq_t  RST_IRQ  = 2'h0;
	localparam abu_addr_t RST_ADDR = 16'h0000;

	// Break vector locations
	localparam abu_addr_t VEC_NORMAL  = 16'hfffc;
	localparam abu_addr_t VEC_MONITOR = 16'hfefc;

	typedef enum logic [1:0] {
		CPU_RUN,
		CPU_WAIT,
		CPU_STOP,
		CPU_BREAK
	} abu_cpu_state_t;

endpackage : abu_pkg

// ===== rtl/abu_sync2.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the level is slow against the clock.
`timescale 1ns/1ps
module abu_sync2 (
	// Clock and control
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// Level
	input  wire logic d,
	output logic      q
);
	logic meta_ff;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= 1'b0;
			q       <= 1'b0;
		end else if (ce) begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end

endmodule : abu_sync2

// ===== sim/abu_checker.sv
// Concurrent checks on the breakpoint link.
// Assumes one clock with CE held high; sees the link signals only.
`timescale 1ns/1ps
module abu_checker (
	// Clock and reset
	input wire logic                   CLK,
	input wire logic                   RST,
	// Link signals
	input wire abu_pkg::abu_addr_t     bus_addr,
	input wire logic                   addr_from_pc,
	input wire abu_pkg::abu_reg_addr_t reg_addr,
	input wire abu_pkg::abu_byte_t     reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire abu_pkg::abu_byte_t     reg_rdata,
	input wire logic                   brk_req,
	input wire abu_pkg::abu_addr_t     vec_addr,
	input wire logic                   in_break,
	input wire logic                   low_wait,
	input wire logic                   low_stop
);
	import abu_pkg::*;
	logic      en_ff;
	abu_addr_t match_ff;
	// Shadow of match registers, so no probing inside the unit
	always_ff @(posedge CLK) begin
		if (RST) begin
			en_ff    <= 1'h0;
			match_ff <= RST_ADDR;
		end else if (reg_wr) begin
			if (reg_addr == OFS_CTRL) en_ff <= reg_wdata[BIT_MATCH_EN];
			if (reg_addr == OFS_MATCH_HI) match_ff[15:8] <= reg_wdata;
			if (reg_addr == OFS_MATCH_LO) match_ff[7:0] <= reg_wdata;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	sequence s_match;
		en_ff && addr_from_pc && !in_break && bus_addr == match_ff;
	endsequence
	sequence s_sw_start;
		reg_wr && reg_addr == OFS_CTRL && reg_wdata[BIT_ACTIVE] && !in_break;
	endsequence
	match_req_a: assert property (s_match |=> brk_req)
		else $error("match gave no request");
	req_cause_a: assert property ($rose(brk_req) |->
		$past(en_ff && addr_from_pc && bus_addr == match_ff)
		|| $past(reg_wr && reg_addr == OFS_CTRL && reg_wdata[BIT_ACTIVE]))
		else $error("request without cause");
	sw_break_a: assert property (s_sw_start |=> brk_req)
		else $error("active write gave no request");
	req_drop_a: assert property ($rose(in_break) |=> !brk_req)
		else $error("request kept after break taken");
	wake_exit_a: assert property ((low_wait || low_stop) && brk_req |=>
		in_break && !low_wait && !low_stop)
		else $error("no wake into break");
	break_quiet_a: assert property (in_break && !brk_req |=> !brk_req)
		else $error("request inside break");
	rd_high_a: assert property (reg_rd && reg_addr == OFS_MATCH_HI |=>
		reg_rdata == match_ff[15:8])
		else $error("match high byte read wrong");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == RST_BYTE)
		else $error("read data outside read slot");
	vec_sel_a: assert property (vec_addr == VEC_NORMAL || vec_addr == VEC_MONITOR)
		else $error("vector location neither normal nor monitor");
endmodule : abu_checker

// ===== sim/tb_address_breakpoint_unit.sv
// Bench joining the breakpoint unit and its CPU end over one link.
// Assumes CE always high; software drives the register port.
`timescale 1ns/1ps
module tb_address_breakpoint_unit;
	import abu_pkg::*;
	logic          clk = 1'h0;
	logic          rst = 1'h1;
	abu_reg_addr_t sw_addr = 3'h0;
	abu_byte_t     sw_wdata = 8'h00;
	logic          sw_wr = 1'h0;
	logic          sw_rd = 1'h0;
	abu_addr_t     core_addr = 16'h0000;
	logic          core_pc = 1'h0;
	logic          instr_last = 1'h0;
	logic [2:0]    kind = 3'h0;
	logic          monitor = 1'h0;
	logic          test_volt = 1'h0;
	abu_byte_t     sw_rdata;
	abu_addr_t     vector_addr;
	logic          subst_swi, break_state, wait_state, stop_state;
	logic          timer_hold, wdog_off, flag_clear_ok, irq;
	int            err_count = 0;
	int            n_tests = 0;
	int            cycles = 0;
	always #5 clk = ~clk;
	abu_if abu_if_inst ();
	abu_break_unit abu_break_unit_inst (
		.CLK(clk), .RST(rst), .CE(1'h1), .LINK(abu_if_inst),
		.MONITOR_MODE(monitor), .TEST_VOLT_PIN(test_volt), .TIMER_HOLD(timer_hold),
		.WDOG_DISABLE(wdog_off), .FLAG_CLEAR_OK(flag_clear_ok), .IRQ(irq)
	);
	abu_cpu_end abu_cpu_end_inst (
		.CLK(clk), .RST(rst), .CE(1'h1), .LINK(abu_if_inst),
		.SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd),
		.SW_RDATA(sw_rdata), .CORE_ADDR(core_addr), .CORE_ADDR_FROM_PC(core_pc),
		.INSTR_LAST(instr_last), .RTI_EXEC(kind[2]), .WAIT_EXEC(kind[1]),
		.STOP_EXEC(kind[0]), .SUBST_SWI(subst_swi), .VECTOR_ADDR(vector_addr),
		.BREAK_STATE(break_state), .WAIT_STATE(wait_state), .STOP_STATE(stop_state)
	);
	abu_checker abu_checker_inst (
		.CLK(clk), .RST(rst), .bus_addr(abu_if_inst.bus_addr),
		.addr_from_pc(abu_if_inst.addr_from_pc), .reg_addr(abu_if_inst.reg_addr),
		.reg_wdata(abu_if_inst.reg_wdata), .reg_wr(abu_if_inst.reg_wr),
		.reg_rd(abu_if_inst.reg_rd), .reg_rdata(abu_if_inst.reg_rdata),
		.brk_req(abu_if_inst.brk_req), .vec_addr(abu_if_inst.vec_addr),
		.in_break(abu_if_inst.in_break), .low_wait(abu_if_inst.low_wait),
		.low_stop(abu_if_inst.low_stop)
	);
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// Off-edge sampling keeps checks clear of edge races
	task automatic pk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : pk
	task automatic wr(input abu_reg_addr_t a, input abu_byte_t d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'h1;
		@(posedge clk);
		sw_wr <= 1'h0;
	endtask : wr
	task automatic rd(input abu_reg_addr_t a, input abu_byte_t e, input string n);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'h1;
		@(posedge clk);
		sw_rd <= 1'h0;
		#1;
		chk(n, sw_rdata, e);
	endtask : rd
	// One core cycle; kind is return, wait, stop
	task automatic core(input abu_addr_t a, input logic pc, input logic last, input logic [2:0] k);
		@(posedge clk);
		core_addr <= a;
		core_pc <= pc;
		instr_last <= last;
		kind <= k;
		@(posedge clk);
		core_pc <= 1'h0;
		instr_last <= 1'h0;
		kind <= 3'h0;
	endtask : core
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 8; i++) rd(abu_reg_addr_t'(i), 8'h00, "reset");
		chk("clear ok", flag_clear_ok, 1'h1);
		wr(OFS_MATCH_HI, 8'h12);
		wr(OFS_MATCH_LO, 8'h34);
		wr(OFS_IRQ_MASK, 8'h03);
		rd(OFS_MATCH_LO, 8'h34, "low");
		rd(OFS_MATCH_HI, 8'h12, "high");
		rd(3'h7, 8'h00, "unmapped");
		// Near misses: not from PC, one bit off, enable clear
		for (int i = 0; i < 3; i++) begin
			wr(OFS_CTRL, i == 2 ? 8'h00 : 8'h80);
			core(i == 1 ? 16'h1235 : 16'h1234, i > 0, 1'h1, 3'h0);
			pk(3);
			chk("miss", break_state, 1'h0);
		end
		wr(OFS_CTRL, 8'h80);
		core(16'h1234, 1'h1, 1'h1, 3'h0);
		pk(1);
		chk("swi", subst_swi, 1'h1);
		chk("vec", vector_addr, VEC_NORMAL);
		pk(1);
		chk("hold", timer_hold, 1'h1);
		chk("clear ok", flag_clear_ok, 1'h0);
		rd(OFS_CTRL, 8'hc0, "active");
		chk("irq", irq, 1'h1);
		wr(OFS_IRQ_MASK, 8'h00);
		pk(2);
		chk("masked", irq, 1'h0);
		wr(OFS_IRQ_MASK, 8'h03);
		wr(OFS_IRQ_STAT, 8'h01);
		rd(OFS_IRQ_STAT, 8'h01, "kept");
		wr(OFS_FLAG_CTRL, 8'h80);
		wr(OFS_IRQ_STAT, 8'h01);
		rd(OFS_IRQ_STAT, 8'h00, "cleared");
		chk("irq off", irq, 1'h0);
		chk("clear ok", flag_clear_ok, 1'h1);
		@(posedge clk);
		test_volt <= 1'h1;
		pk(4);
		chk("wdog", wdog_off, 1'h1);
		wr(OFS_CTRL, 8'h80);
		rd(OFS_CTRL, 8'h80, "active off");
		core(16'h0000, 1'h0, 1'h1, 3'h4);
		pk(0);
		chk("end", break_state, 1'h0);
		pk(1);
		chk("run", timer_hold, 1'h0);
		chk("wdog on", wdog_off, 1'h0);
		// Mid-instruction match waits for the boundary
		@(posedge clk);
		monitor <= 1'h1;
		core(16'h1234, 1'h1, 1'h0, 3'h0);
		pk(4);
		chk("early", break_state, 1'h0);
		core(16'h0000, 1'h0, 1'h1, 3'h0);
		pk(1);
		chk("mon vec", vector_addr, VEC_MONITOR);
		wr(OFS_CTRL, 8'h80);
		core(16'h0000, 1'h0, 1'h1, 3'h4);
		// Wake from wait by match, from stop by software start
		for (int k = 0; k < 2; k++) begin
			core(16'h0000, 1'h0, 1'h1, k ? 3'h1 : 3'h2);
			pk(1);
			chk("low", k ? stop_state : wait_state, 1'h1);
			if (k) wr(OFS_CTRL, 8'hc0);
			else core(16'h1234, 1'h1, 1'h0, 3'h0);
			pk(1);
			chk("wake", break_state, 1'h1);
			rd(OFS_WAIT_STAT, 8'h02, "exit flag");
			rd(OFS_IRQ_STAT, 8'h03, "wake irq");
			wr(OFS_WAIT_STAT, 8'h02);
			rd(OFS_WAIT_STAT, 8'h02, "exit kept");
			wr(OFS_WAIT_STAT, 8'h00);
			rd(OFS_WAIT_STAT, 8'h00, "exit clear");
			wr(OFS_CTRL, 8'h80);
			core(16'h0000, 1'h0, 1'h1, 3'h4);
		end
		finish_test();
	end
endmodule : tb_address_breakpoint_unit
